// File: logic/cee_event_entry.sv
// Event-entry logic: priority, status rewrite, shadow saving, fault recording and handler jump
//
// What this block does
// RULE_01 - NMI input raises an event; the global interrupt mask does not block it.
// RULE_02 - NMI input is ignored while the context is the NMI context 111.
// RULE_03 - NMI entry saves status and return, clears flags, context 111, masks, vector 0x10.
// RULE_04 - Interrupts wait for the pipeline to drain; return is first non-completed instruction.
// RULE_05 - A level is accepted only with global mask and its own mask clear.
// RULE_06 - Accepting a level sets that level's own mask bit.
// RULE_07 - Level 3 entry saves state, context 101, sets level 3, 2, 1 masks.
// RULE_08 - Controller supplies the offset; handler is vector base combined with it.
// RULE_09 - Vector base and offset are combined with bitwise OR, not an adder.
// RULE_10 - Level 2 entry saves state, context 100, sets level 2, 1, 0 masks.
// RULE_11 - Level 1 entry saves state, context 011, sets level 1 and 0 masks.
// RULE_12 - Level 0 entry saves state, context 010, sets level 0 mask.
// RULE_13 - Misaligned fetch saves state, records fault address and page, vector 0x14.
// RULE_14 - Instruction translation miss records fault, side flag 1, vector 0x50.
// RULE_15 - Instruction protection fault records fault, side flag 1, context 110, vector 0x18.
// RULE_16 - Breakpoint while debug mask clear enters debug state, vector 0x1C.
// RULE_17 - Debug return instruction leaves debug state and resumes normal execution.
// RULE_18 - Unknown opcode or unacknowledged coprocessor instruction jumps to vector 0x20.
// RULE_19 - Unimplemented instruction saves PC, masks, jumps to vector 0x24.
// RULE_20 - Misaligned data read records fault address and page, vector 0x34.
// RULE_21 - Misaligned data write records fault, sets both masks, vector 0x38.
// RULE_22 - Data read translation miss records fault, side flag 0, vector 0x60.
// RULE_23 - Data write translation miss records fault, side flag 0, vector 0x70.
// RULE_24 - Any exception while exception mask is set becomes the unrecoverable exception.
// RULE_25 - Simultaneous interrupts: NMI first, then level 3, 2, 1, 0.
//
// Design decisions made here: the register addresses and register access over APB.
`include "cee_regs.svh"

module cee_event_entry
#(
    parameter int PAGE_LSB = 10
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_pin,
    input wire logic lvl3_irq,
    input wire logic lvl2_irq,
    input wire logic lvl1_irq,
    input wire logic lvl0_irq,
    input wire logic onchip_debug_bkpt,
    input wire logic [31:0] irq_vector_offset,
    input wire logic pipe_drained,
    input wire logic [31:0] next_instr_addr,
    input wire logic [31:0] exc_pc,
    input wire logic [31:0] fault_addr,
    input wire logic instr_addr_fault,
    input wire logic instr_xlate_buffer_miss,
    input wire logic instr_xlate_buffer_prot,
    input wire logic bkpt_instr,
    input wire logic illegal_opcode,
    input wire logic cop_nack,
    input wire logic unimpl_instr,
    input wire logic dread_addr_fault,
    input wire logic dwrite_addr_fault,
    input wire logic data_xlate_buffer_read_miss,
    input wire logic data_xlate_buffer_write_miss,
    input wire logic debug_return_instr,
    output logic irq_hold,
    output logic jump_valid,
    output logic [31:0] jump_addr,
    output logic [3:0] lvl_ack,
    output logic [31:0] status_out
);
    // ***************************************************************
    // State
    // ***************************************************************
    cee_pkg::cee_state_t state;
    cee_pkg::cee_state_t next_state;
    logic [31:0] status_reg;
    logic [31:0] next_status;
    logic [31:0] vector_base;
    logic [31:0] fault_vaddr_reg;
    logic [31:0] fault_page_reg;
    logic [31:0] next_fpage;
    logic [31:0] saved_status [0:6];
    logic [31:0] return_addr [0:6];

    // ***************************************************************
    // Event acceptance and priority
    // ***************************************************************
    logic [2:0] ctx;
    logic [3:0] lvl_mask;
    logic gm;
    logic em;
    logic [5:0] gate_pin;
    logic [5:0] gate_block;
    logic [5:0] gate_acc;
    logic [4:0] irq_acc;
    logic [4:0] irq_sel;
    logic [4:0] take_irq;
    logic irq_pend;
    logic irq_go;
    logic bkpt_req;
    logic [9:0] exc_req;
    logic [9:0] exc_sel;
    logic exc_any;
    logic unrec;
    logic entry;

    assign ctx = status_reg[`CEE_SR_CTX_HI:`CEE_SR_CTX_LO];
    assign lvl_mask = status_reg[`CEE_SR_LVL_HI:`CEE_SR_LVL_LO];
    assign gm = status_reg[`CEE_SR_GIRQ_MASK];
    assign em = status_reg[`CEE_SR_EXC_MASK];

    // Slot 0 NMI, slots 1-4 levels 3 to 0, slot 5 debug breakpoint pin
    assign gate_pin = {onchip_debug_bkpt, lvl0_irq, lvl1_irq, lvl2_irq, lvl3_irq, nmi_pin};
    // RULE_01 NMI ignores gm
    // RULE_02 NMI serialised
    // RULE_05 level mask gating
    assign gate_block = {status_reg[`CEE_SR_DBG_MASK], gm | lvl_mask[0], gm | lvl_mask[1],
                         gm | lvl_mask[2], gm | lvl_mask[3], ctx == `CEE_CTX_NMI};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_gate
            cee_sync_gate u_gate
            (
                .core_clk(core_clk),
                .rst(rst),
                .pin_in(gate_pin[gi]),
                .block(gate_block[gi]),
                .accept(gate_acc[gi])
            );
        end
    endgenerate

    // RULE_25 lowest slot wins
    assign irq_acc = gate_acc[4:0];
    assign irq_sel = irq_acc & (~irq_acc + 5'h01);
    assign irq_pend = |irq_acc;
    // RULE_04 wait for drained pipeline
    assign irq_go = (state == cee_pkg::CEE_ST_DRAIN) && pipe_drained && !exc_any && irq_pend;
    assign take_irq = irq_sel & {5{irq_go}};
    assign irq_hold = (state == cee_pkg::CEE_ST_DRAIN);

    // RULE_16 breakpoint gated by debug mask
    assign bkpt_req = (bkpt_instr & ~status_reg[`CEE_SR_DBG_MASK]) | gate_acc[5];
    // RULE_18 opcode or coprocessor fault
    assign exc_req = {data_xlate_buffer_write_miss, data_xlate_buffer_read_miss, dwrite_addr_fault, dread_addr_fault, unimpl_instr,
                      illegal_opcode | cop_nack, bkpt_req, instr_xlate_buffer_prot, instr_xlate_buffer_miss, instr_addr_fault};
    assign exc_sel = exc_req & (~exc_req + 10'h001);
    assign exc_any = |exc_req;
    // RULE_24 exception under exception mask
    assign unrec = exc_any & em;
    assign entry = exc_any | irq_go;

    // Drain state machine: hold issue until the pipeline is empty
    always_comb
    begin
        next_state = state;
        unique case (state)
            cee_pkg::CEE_ST_RUN:
            begin
                if (irq_pend)
                    next_state = cee_pkg::CEE_ST_DRAIN;
            end
            cee_pkg::CEE_ST_DRAIN:
            begin
                if (irq_go || !irq_pend)
                    next_state = cee_pkg::CEE_ST_RUN;
            end
        endcase
    end

    // ***************************************************************
    // Entry attributes
    // ***************************************************************
    logic [31:0] e_vec;
    logic [31:0] e_ret;
    logic [2:0] e_ctx;
    cee_pkg::cee_bank_t e_bank;
    logic e_em;
    logic e_gm;
    logic e_dbg;
    logic [3:0] e_lvl;
    logic e_rec;
    logic e_side_wr;
    logic e_side_val;

    assign e_rec = !unrec && |(exc_sel & `CEE_EXC_FAULT_REC);
    assign e_side_wr = !unrec && |(exc_sel & `CEE_EXC_SIDE_WR);
    assign e_side_val = |(exc_sel & `CEE_EXC_SIDE_VAL);

    // Vector, context, mask set and shadow bank of the winning event
    always_comb
    begin
        e_vec = `CEE_VEC_UNREC;
        e_ret = exc_pc;
        e_ctx = `CEE_CTX_EXC;
        e_bank = cee_pkg::CEE_BANK_EXC;
        e_em = 1'b1;
        e_gm = 1'b1;
        e_dbg = 1'b0;
        e_lvl = 4'h0;
        if (!unrec && exc_any)
        begin
            e_gm = |(exc_sel & `CEE_EXC_GM_SET);
            e_dbg = exc_sel[cee_pkg::CEE_EX_BKPT];
            if (e_dbg)
                e_bank = cee_pkg::CEE_BANK_DBG;
            // RULE_15 RULE_19 RULE_20 RULE_21 RULE_22 exception vectors
            unique case (1'b1)
                exc_sel[cee_pkg::CEE_EX_IADDR]: e_vec = `CEE_VEC_IADDR;
                exc_sel[cee_pkg::CEE_EX_INSTR_XLATE_BUFFER_MISS]: e_vec = `CEE_VEC_INSTR_XLATE_BUFFER_MISS;
                exc_sel[cee_pkg::CEE_EX_INSTR_XLATE_BUFFER_PROT]: e_vec = `CEE_VEC_INSTR_XLATE_BUFFER_PROT;
                exc_sel[cee_pkg::CEE_EX_BKPT]: e_vec = `CEE_VEC_BKPT;
                exc_sel[cee_pkg::CEE_EX_ILLEGAL]: e_vec = `CEE_VEC_ILLEGAL;
                exc_sel[cee_pkg::CEE_EX_UNIMPL]: e_vec = `CEE_VEC_UNIMPL;
                exc_sel[cee_pkg::CEE_EX_DRADDR]: e_vec = `CEE_VEC_DRADDR;
                exc_sel[cee_pkg::CEE_EX_DWADDR]: e_vec = `CEE_VEC_DWADDR;
                exc_sel[cee_pkg::CEE_EX_DATA_XLATE_BUFFER_RMISS]: e_vec = `CEE_VEC_DATA_XLATE_BUFFER_RMISS;
                exc_sel[cee_pkg::CEE_EX_DATA_XLATE_BUFFER_WMISS]: e_vec = `CEE_VEC_DATA_XLATE_BUFFER_WMISS;
            endcase
        end
        else if (!unrec)
        begin
            // RULE_08 controller offset
            e_vec = irq_vector_offset;
            e_ret = next_instr_addr;
            e_em = 1'b0;
            e_gm = 1'b0;
            unique case (1'b1)
                take_irq[0]:
                begin
                    // RULE_03 NMI entry values
                    e_vec = `CEE_VEC_NMI;
                    e_ctx = `CEE_CTX_NMI;
                    e_bank = cee_pkg::CEE_BANK_NMI;
                    e_em = 1'b1;
                    e_gm = 1'b1;
                end
                take_irq[1]:
                begin
                    // RULE_07 level 3 entry
                    e_ctx = `CEE_CTX_L3;
                    e_bank = cee_pkg::CEE_BANK_L3;
                    e_lvl = `CEE_LVLSET_L3;
                end
                take_irq[2]:
                begin
                    // RULE_10 level 2 entry
                    e_ctx = `CEE_CTX_L2;
                    e_bank = cee_pkg::CEE_BANK_L2;
                    e_lvl = `CEE_LVLSET_L2;
                end
                take_irq[3]:
                begin
                    // RULE_11 level 1 entry
                    e_ctx = `CEE_CTX_L1;
                    e_bank = cee_pkg::CEE_BANK_L1;
                    e_lvl = `CEE_LVLSET_L1;
                end
                take_irq[4]:
                begin
                    // RULE_12 level 0 entry
                    e_ctx = `CEE_CTX_L0;
                    e_bank = cee_pkg::CEE_BANK_L0;
                    e_lvl = `CEE_LVLSET_L0;
                end
                default:
                begin
                    e_ctx = ctx;
                end
            endcase
        end
    end

    // ***************************************************************
    // Status and fault register next values
    // ***************************************************************
    logic apb_wr;
    logic sr_wr;
    logic vb_wr;

    assign apb_wr = psel & penable & pwrite;
    assign sr_wr = apb_wr && (paddr == `CEE_OFS_STATUS);
    assign vb_wr = apb_wr && (paddr == `CEE_OFS_VBASE);

    // Software write, debug return, then event entry on top
    always_comb
    begin
        next_status = status_reg;
        if (sr_wr)
            next_status = pwdata;
        // RULE_17 leave debug state
        if (debug_return_instr && status_reg[`CEE_SR_DBG_STATE])
        begin
            next_status = saved_status[cee_pkg::CEE_BANK_DBG];
            next_status[`CEE_SR_DBG_STATE] = 1'b0;
        end
        if (entry)
        begin
            next_status[`CEE_SR_REMAP] = 1'b0;
            next_status[`CEE_SR_BYTECODE] = 1'b0;
            next_status[`CEE_SR_CTX_HI:`CEE_SR_CTX_LO] = e_ctx;
            next_status[`CEE_SR_EXC_MASK] = next_status[`CEE_SR_EXC_MASK] | e_em;
            next_status[`CEE_SR_GIRQ_MASK] = next_status[`CEE_SR_GIRQ_MASK] | e_gm;
            // RULE_06 set own level mask
            next_status[`CEE_SR_LVL_HI:`CEE_SR_LVL_LO] = next_status[`CEE_SR_LVL_HI:`CEE_SR_LVL_LO] | e_lvl;
            next_status[`CEE_SR_DBG_STATE] = next_status[`CEE_SR_DBG_STATE] | e_dbg;
            next_status[`CEE_SR_DBG_MASK] = next_status[`CEE_SR_DBG_MASK] | e_dbg;
        end
    end

    // RULE_13 fault page recording
    // RULE_14 instruction side flag
    // RULE_23 data side flag
    always_comb
    begin
        next_fpage = fault_page_reg;
        if (entry && e_rec)
            next_fpage[31:PAGE_LSB] = fault_addr[31:PAGE_LSB];
        if (entry && e_side_wr)
            next_fpage[`CEE_FP_SIDE] = e_side_val;
    end

    // Core event state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= cee_pkg::CEE_ST_RUN;
            status_reg <= `CEE_SR_RST;
            vector_base <= `CEE_VBASE_RST;
            fault_vaddr_reg <= 32'h0000_0000;
            fault_page_reg <= 32'h0000_0000;
            jump_valid <= 1'b0;
            jump_addr <= 32'h0000_0000;
            lvl_ack <= 4'h0;
        end
        else
        begin
            state <= next_state;
            status_reg <= next_status;
            vector_base <= vb_wr ? pwdata : vector_base;
            fault_vaddr_reg <= (entry && e_rec) ? fault_addr : fault_vaddr_reg;
            fault_page_reg <= next_fpage;
            jump_valid <= entry;
            // RULE_09 OR, not add
            jump_addr <= entry ? (vector_base | e_vec) : jump_addr;
            lvl_ack <= {take_irq[1], take_irq[2], take_irq[3], take_irq[4]};
        end
    end

    // RULE_03 shadow save on entry
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 7; i++)
            begin
                saved_status[i] <= 32'h0000_0000;
                return_addr[i] <= 32'h0000_0000;
            end
        end
        else if (entry)
        begin
            saved_status[e_bank] <= status_reg;
            return_addr[e_bank] <= e_ret;
        end
    end

    assign status_out = status_reg;

    // ***************************************************************
    // APB slave
    // ***************************************************************
    logic [31:0] rd_word;
    logic [3:0] rd_slot;
    logic in_shadow;
    logic mapped;

    assign pready = 1'b1;
    assign rd_slot = paddr[6:3] - 4'h2;
    assign in_shadow = (paddr >= `CEE_OFS_SHADOW) && (paddr < `CEE_OFS_END);
    assign mapped = (paddr < `CEE_OFS_END) && (paddr[1:0] == 2'b00);

    // Read word selection
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (in_shadow)
            rd_word = paddr[2] ? return_addr[rd_slot[2:0]] : saved_status[rd_slot[2:0]];
        else if (paddr == `CEE_OFS_STATUS)
            rd_word = status_reg;
        else if (paddr == `CEE_OFS_VBASE)
            rd_word = vector_base;
        else if (paddr == `CEE_OFS_FVADDR)
            rd_word = fault_vaddr_reg;
        else if (paddr == `CEE_OFS_FPAGE)
            rd_word = fault_page_reg;
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= (mapped && !pwrite) ? rd_word : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cee_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_NMI_NO_GM: // RULE_01
    assert property (irq_go && irq_acc[0] |-> take_irq[0]) else $error("NMI not taken when ready");
    AST_NMI_SERIAL: // RULE_02
    assert property (ctx == `CEE_CTX_NMI |-> !take_irq[0]) else $error("NMI taken inside NMI handler");
    AST_NMI_ENTRY: // RULE_03
    assert property (take_irq[0] |=> jump_valid && jump_addr == ($past(vector_base) | `CEE_VEC_NMI)
        && ctx == `CEE_CTX_NMI && em && gm) else $error("NMI entry state wrong");
    AST_DRAINED: // RULE_04
    assert property (|take_irq |-> pipe_drained ##1 return_addr[$past(e_bank)] == $past(next_instr_addr))
        else $error("Interrupt entered before drain");
    AST_LVL_GM: // RULE_05
    assert property (gm |-> take_irq[4:1] == 4'h0) else $error("Level taken under global mask");
    AST_LVL_SELF: // RULE_06
    assert property (take_irq[4] |=> lvl_mask[0] && ctx == `CEE_CTX_L0) else $error("Level 0 mask not set");
    AST_LVL3_ENTRY: // RULE_07
    assert property (take_irq[1] |=> saved_status[cee_pkg::CEE_BANK_L3] == $past(status_reg)
        && ctx == `CEE_CTX_L3 && lvl_mask[3:1] == 3'b111) else $error("Level 3 entry wrong");
    AST_AUTOVEC: // RULE_09
    assert property (|take_irq[4:1] |=> jump_addr == ($past(vector_base) | $past(irq_vector_offset)))
        else $error("Autovector address wrong");
    AST_INSTR_XLATE_BUFFER_MISS: // RULE_14
    assert property (exc_sel[cee_pkg::CEE_EX_INSTR_XLATE_BUFFER_MISS] && !em |=> fault_page_reg[`CEE_FP_SIDE]
        && fault_vaddr_reg == $past(fault_addr) && jump_addr == ($past(vector_base) | `CEE_VEC_INSTR_XLATE_BUFFER_MISS))
        else $error("Instruction translation miss entry wrong");
    AST_BKPT: // RULE_16
    assert property (exc_sel[cee_pkg::CEE_EX_BKPT] && !em |=> status_reg[`CEE_SR_DBG_STATE]
        && status_reg[`CEE_SR_DBG_MASK] && gm && jump_addr == ($past(vector_base) | `CEE_VEC_BKPT))
        else $error("Breakpoint entry wrong");
    AST_DRET: // RULE_17
    assert property (debug_return_instr && status_reg[`CEE_SR_DBG_STATE] && !entry
        |=> !status_reg[`CEE_SR_DBG_STATE]) else $error("Debug state not left");
    AST_UNREC: // RULE_24
    assert property (unrec |=> jump_valid && jump_addr == $past(vector_base)
        && return_addr[cee_pkg::CEE_BANK_EXC] == $past(exc_pc)) else $error("Unrecoverable entry wrong");
    AST_PRIO: // RULE_25
    assert property (irq_go && irq_acc[1] && !irq_acc[0] |-> take_irq == 5'h02) else $error("Priority wrong");

    COV_NMI: cover property (take_irq[0] ##1 jump_valid);
    COV_LVL_DRAIN: cover property (irq_hold && !pipe_drained ##1 irq_go);
    COV_UNREC: cover property (unrec);
    COV_DEBUG: cover property (exc_sel[cee_pkg::CEE_EX_BKPT] ##[1:20] debug_return_instr);
endmodule

// File: logic/cee_pkg.sv
// Types shared by the event-entry block
package cee_pkg;
    typedef enum logic [1:0] {CEE_ST_RUN = 2'b01, CEE_ST_DRAIN = 2'b10} cee_state_t;
    typedef enum logic [2:0] {
        CEE_BANK_NMI = 3'h0, CEE_BANK_L3 = 3'h1, CEE_BANK_L2 = 3'h2, CEE_BANK_L1 = 3'h3,
        CEE_BANK_L0 = 3'h4, CEE_BANK_EXC = 3'h5, CEE_BANK_DBG = 3'h6
    } cee_bank_t;
    typedef enum logic [3:0] {
        CEE_EX_IADDR = 4'h0, CEE_EX_INSTR_XLATE_BUFFER_MISS = 4'h1, CEE_EX_INSTR_XLATE_BUFFER_PROT = 4'h2, CEE_EX_BKPT = 4'h3,
        CEE_EX_ILLEGAL = 4'h4, CEE_EX_UNIMPL = 4'h5, CEE_EX_DRADDR = 4'h6, CEE_EX_DWADDR = 4'h7,
        CEE_EX_DATA_XLATE_BUFFER_RMISS = 4'h8, CEE_EX_DATA_XLATE_BUFFER_WMISS = 4'h9
    } cee_exc_t;
endpackage

// File: logic/cee_regs.svh
// Register offsets, status field positions, reset values and vector offsets of the event-entry block
`ifndef CEE_REGS_SVH
`define CEE_REGS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CEE_OFS_STATUS 8'h00
`define CEE_OFS_VBASE 8'h04
`define CEE_OFS_FVADDR 8'h08
`define CEE_OFS_FPAGE 8'h0C
`define CEE_OFS_SHADOW 8'h10
`define CEE_OFS_END 8'h48

// ***************************************************************
// Status register fields
// ***************************************************************
`define CEE_SR_REMAP 15
`define CEE_SR_GIRQ_MASK 16
`define CEE_SR_LVL_LO 17
`define CEE_SR_LVL_HI 20
`define CEE_SR_EXC_MASK 21
`define CEE_SR_CTX_LO 22
`define CEE_SR_CTX_HI 24
`define CEE_SR_DBG_MASK 26
`define CEE_SR_DBG_STATE 27
`define CEE_SR_BYTECODE 28
`define CEE_SR_RST 32'h0021_0000
`define CEE_VBASE_RST 32'h0000_0000
`define CEE_FP_SIDE 0

// ***************************************************************
// Execution contexts and level mask sets
// ***************************************************************
`define CEE_CTX_NMI 3'h7
`define CEE_CTX_EXC 3'h6
`define CEE_CTX_L3 3'h5
`define CEE_CTX_L2 3'h4
`define CEE_CTX_L1 3'h3
`define CEE_CTX_L0 3'h2
`define CEE_LVLSET_L3 4'hE
`define CEE_LVLSET_L2 4'h7
`define CEE_LVLSET_L1 4'h3
`define CEE_LVLSET_L0 4'h1

// ***************************************************************
// Handler offsets and per-exception attribute masks
// ***************************************************************
`define CEE_VEC_UNREC 32'h0000_0000
`define CEE_VEC_NMI 32'h0000_0010
`define CEE_VEC_IADDR 32'h0000_0014
`define CEE_VEC_INSTR_XLATE_BUFFER_PROT 32'h0000_0018
`define CEE_VEC_BKPT 32'h0000_001C
`define CEE_VEC_ILLEGAL 32'h0000_0020
`define CEE_VEC_UNIMPL 32'h0000_0024
`define CEE_VEC_DRADDR 32'h0000_0034
`define CEE_VEC_DWADDR 32'h0000_0038
`define CEE_VEC_INSTR_XLATE_BUFFER_MISS 32'h0000_0050
`define CEE_VEC_DATA_XLATE_BUFFER_RMISS 32'h0000_0060
`define CEE_VEC_DATA_XLATE_BUFFER_WMISS 32'h0000_0070
`define CEE_EXC_GM_SET 10'h1B8
`define CEE_EXC_FAULT_REC 10'h3C7
`define CEE_EXC_SIDE_WR 10'h306
`define CEE_EXC_SIDE_VAL 10'h006

`endif

// File: logic/cee_sync_gate.sv
// Pin synchroniser with a blocking gate for one asynchronous event input
module cee_sync_gate
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pin_in,
    input wire logic block,
    output logic accept
);
    logic meta;
    logic sync;

    // Two flops before any logic reads the pin
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            sync <= meta;
        end
    end

    // Request passes only while not blocked
    assign accept = sync & ~block;
endmodule

// File: verification/cee_irq_ctrl.sv
// Interrupt controller and pipeline-drain model beside the event-entry block
module cee_irq_ctrl
(
    input wire logic core_clk,
    input wire logic [3:0] lvl_req,
    input wire logic irq_hold,
    input wire logic slow,
    output logic [31:0] irq_vector_offset,
    output logic pipe_drained
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = '0;
    assign irq_vector_offset = lvl_req[3] ? 32'h0000_0130 : lvl_req[2] ? 32'h0000_0120 :
        lvl_req[1] ? 32'h0000_0110 : 32'h0000_0100;
    // Slow mode keeps instructions in flight for eight cycles
    assign pipe_drained = irq_hold && (!slow || cnt[3]);
    always @(posedge core_clk)
        cnt <= irq_hold ? cnt + {3'h0, !cnt[3]} : 4'h0;
endmodule

// File: verification/tb.sv
// Self-checking bench for the event-entry block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VB = 32'h0000_4110;
    logic core_clk = '0, rst = 1'h1, psel = '0, penable = '0, pwrite = '0, nmi_pin = '0, slow = '0, e;
    logic lvl3_irq = '0, lvl2_irq = '0, lvl1_irq = '0, lvl0_irq = '0, onchip_debug_bkpt = '0;
    logic debug_return_instr = '0, pready, pslverr, irq_hold, jump_valid, pipe_drained;
    logic [3:0] lvl_ack;
    logic [7:0] paddr = '0;
    logic [10:0] ex = '0;
    logic [31:0] pwdata = '0, next_instr_addr = 32'h0A00, exc_pc = 32'h0B00, fault_addr = 32'h1C06;
    logic [31:0] prdata, jump_addr, status_out, irq_vector_offset, r;
    // Rows: exception input index, global mask expected, handler offset
    logic [15:0] rows [11] = '{16'h0014, 16'h1050, 16'h2018, 16'h311C, 16'h4120, 16'h5120, 16'h6124,
        16'h7034, 16'h8138, 16'h9160, 16'hA070};
    int error_cnt = 0, num_checks = 0, cyc = 0;
    cee_event_entry cee_event_entry_i (.*, .instr_addr_fault(ex[0]), .instr_xlate_buffer_miss(ex[1]), .instr_xlate_buffer_prot(ex[2]),
        .bkpt_instr(ex[3]), .illegal_opcode(ex[4]), .cop_nack(ex[5]), .unimpl_instr(ex[6]),
        .dread_addr_fault(ex[7]), .dwrite_addr_fault(ex[8]), .data_xlate_buffer_read_miss(ex[9]), .data_xlate_buffer_write_miss(ex[10]));
    cee_irq_ctrl cee_irq_ctrl_i (.core_clk, .lvl_req({lvl3_irq, lvl2_irq, lvl1_irq, lvl0_irq}), .irq_hold,
        .slow, .irq_vector_offset, .pipe_drained);
    always #12.5 core_clk = ~core_clk;
    // Cycle ceiling against hangs
    always @(posedge core_clk)
        if (++cyc == 4000)
        begin
            error_cnt++;
            wrap_up();
        end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // Bounded wait for a handler jump; flags whether one came
    task automatic wj(input logic want);
        int n;
        #1;
        for (n = 0; n < 40 && jump_valid !== 1'b1; n++)
            @(posedge core_clk) #1;
        chk({31'h0, n < 40}, {31'h0, want});
    endtask
    task automatic wrap_up();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        apb(1'h0, 8'h00, 32'h0);
        chk(r, 32'h0021_0000);
        apb(1'h1, 8'h04, VB);
        apb(1'h0, 8'h48, 32'h0);
        chk({31'h0, e}, 32'h1);
        foreach (rows[i])
        begin
            apb(1'h1, 8'h00, 32'h0);
            ex <= 11'h1 << rows[i][15:12];
            @(posedge core_clk);
            ex <= 11'h0;
            wj(1'h1);
            chk(jump_addr, VB | rows[i][7:0]);
            chk({status_out[24:21], status_out[16]}, {4'hD, rows[i][8]});
        end
        apb(1'h0, 8'h08, 32'h0);
        chk(r, fault_addr);
        apb(1'h0, 8'h0C, 32'h0);
        chk(r, 32'h0000_1C00);
        ex <= 11'h010;
        @(posedge core_clk);
        ex <= 11'h0;
        wj(1'h1);
        chk(jump_addr, VB);
        apb(1'h1, 8'h00, 32'h0001_0000);
        nmi_pin <= 1'h1;
        wj(1'h1);
        chk(jump_addr, VB | 32'h10);
        chk(status_out[24:16], 32'h1E1);
        @(posedge core_clk);
        wj(1'h0);
        apb(1'h0, 8'h14, 32'h0);
        chk(r, next_instr_addr);
        nmi_pin <= 1'h0;
        apb(1'h1, 8'h00, 32'h0001_0000);
        {lvl3_irq, lvl0_irq, slow} <= 3'h7;
        wj(1'h0);
        apb(1'h1, 8'h00, 32'h0);
        repeat (4) @(posedge core_clk);
        #1;
        chk({31'h0, irq_hold}, 32'h1);
        wj(1'h1);
        chk(jump_addr, VB | 32'h130);
        chk({28'h0, lvl_ack}, 32'h8);
        chk(status_out[24:16], 32'h15C);
        @(posedge core_clk);
        lvl3_irq <= 1'h0;
        wj(1'h1);
        chk(jump_addr, VB | 32'h100);
        chk(status_out[24:16], 32'h09E);
        @(posedge core_clk);
        {lvl2_irq, lvl1_irq, lvl0_irq} <= 3'h6;
        apb(1'h1, 8'h00, 32'h0);
        wj(1'h1);
        chk(jump_addr, VB | 32'h120);
        chk({28'h0, lvl_ack}, 32'h4);
        chk(status_out[24:16], 32'h10E);
        @(posedge core_clk);
        lvl2_irq <= 1'h0;
        apb(1'h1, 8'h00, 32'h0);
        wj(1'h1);
        chk({28'h0, lvl_ack}, 32'h2);
        chk(status_out[24:16], 32'h0C6);
        @(posedge core_clk);
        lvl1_irq <= 1'h0;
        apb(1'h1, 8'h00, 32'h0000_8000);
        onchip_debug_bkpt <= 1'h1;
        wj(1'h1);
        chk(jump_addr, VB | 32'h1C);
        @(posedge core_clk);
        onchip_debug_bkpt <= 1'h0;
        repeat (2) @(posedge core_clk);
        debug_return_instr <= 1'h1;
        @(posedge core_clk);
        debug_return_instr <= 1'h0;
        #1;
        chk(status_out, 32'h0000_8000);
        wrap_up();
    end
endmodule
